// ---- rtl/iowdg_pkg.sv ----
// Purpose: Shared constants and types for the port-mapped watchdog.
// Assumes: The host reaches the block over a simple byte-wide I/O port.
// Notes: Timeouts are held in ms or s and counted in 1 ms ticks at 25 MHz.
// How it works
// - A read of port 066h restarts the watchdog countdown.
// - The data returned by a read of port 066h is meaningless to the host.
// - Port 062h is the configuration register and is readable and writable.
// - Bit 0 of the configuration register enables the countdown.
// - The mode bit picks millisecond timeouts (0) or second timeouts (1).
// - Bits 5:3 pick one of eight timeouts, 94 ms / 2 s being the default.
// - Bit 7 reads 1 after an alarm and writing 1 there clears it and the LED; an expiry in the same cycle wins and keeps both set.
`default_nettype none
package iowdg_pkg;
  localparam logic [15:0] IOWDG_CFG_ADDR = 16'h0062;
  localparam logic [15:0] IOWDG_TRIG_ADDR = 16'h0066;
  localparam int IOWDG_EN_BIT = 0;
  localparam int IOWDG_MODE_BIT = 1;
  localparam int IOWDG_SEL_LSB = 3;
  localparam int IOWDG_LED_BIT = 6;
  localparam int IOWDG_ALARM_BIT = 7;
  localparam logic [7:0] IOWDG_CFG_RESET = 8'h00;
  localparam logic [7:0] IOWDG_TRIG_READ = 8'h00;
  localparam int IOWDG_CLK_HZ = 25000000;
  localparam int IOWDG_TICK_CYCLES = IOWDG_CLK_HZ / 1000;
  // Normal-mode timeouts in ms, macro-mode timeouts in s, by code.
  localparam int IOWDG_NORM_MS [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
  localparam int IOWDG_MACRO_S [8] = '{2, 4, 6, 8, 16, 32, 48, 64};
  localparam int IOWDG_MS_PER_S = 1000;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } iowdg_req_s;
endpackage
`default_nettype wire

// ---- rtl/iowdg_tick.sv ----
// Purpose: Divider giving a one-cycle pulse every millisecond.
// Assumes: One system clock; the pulse serves as a clock enable.
// Notes: The count restarts on i_clr so a restart is exact to the tick.
`default_nettype none
module iowdg_tick #(
  parameter int DIV = 25000
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst_b, // Synchronous reset, active low.
  input wire logic i_clr, // Restart the divider.
  output logic o_tick // One-cycle pulse each period.
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  wire at_end = (cnt_ff == 16'(DIV - 1));

  // Count up and wrap at the end of each period.
  assign nxt_cnt = (i_clr || at_end) ? 16'h0000 : cnt_ff + 16'h0001;
  assign o_tick = at_end && !i_clr;

  // Divider counter.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      cnt_ff <= 16'h0000;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule
`default_nettype wire

// ---- rtl/iowdg_top.sv ----
// Purpose: Port-mapped watchdog with configuration and retrigger ports.
// Assumes: Host strobes are single-cycle and synchronous to i_sys_clk.
// Notes: Timeout is counted in millisecond ticks from a divider.
`default_nettype none
module iowdg_top #(
  parameter int TICK_CYCLES = iowdg_pkg::IOWDG_TICK_CYCLES
) (
  input wire logic i_sys_clk, // System clock, 25 MHz.
  input wire logic i_rst_b, // Synchronous reset, active low.
  input wire iowdg_pkg::iowdg_req_s i_req, // Host I/O request.
  output logic [7:0] o_rdata, // Read data, registered.
  output logic o_rvalid, // Read data valid pulse.
  output logic o_led_on, // Red alarm LED, active high.
  output logic o_alarm // Alarm status level.
);
  logic en_ff;
  logic mode_ff;
  logic [2:0] sel_ff;
  logic led_ff;
  logic alarm_ff;
  logic [16:0] ms_ff;
  logic [16:0] nxt_ms;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic tick;

  // Address decode of the two ports.
  wire cfg_hit = (i_req.addr == iowdg_pkg::IOWDG_CFG_ADDR);
  wire trig_hit = (i_req.addr == iowdg_pkg::IOWDG_TRIG_ADDR);
  wire cfg_wr = cfg_hit && i_req.wr;
  wire retrig = trig_hit && i_req.rd;
  wire clr_alarm = cfg_wr && i_req.wdata[iowdg_pkg::IOWDG_ALARM_BIT];

  // Selected timeout in ms, from mode and code.
  wire [16:0] limit_ms = mode_ff ?
    17'(iowdg_pkg::IOWDG_MACRO_S[sel_ff] * iowdg_pkg::IOWDG_MS_PER_S) :
    17'(iowdg_pkg::IOWDG_NORM_MS[sel_ff]);
  wire expire = en_ff && tick && (ms_ff + 17'h00001 >= limit_ms);

  // Count restarts on retrigger, while disabled and on expiry.
  assign nxt_ms = (retrig || !en_ff || expire) ? 17'h00000 :
    (tick ? ms_ff + 17'h00001 : ms_ff);

  // Readback of the configuration; retrigger reads return a fixed byte.
  wire [7:0] cfg_view = {alarm_ff, led_ff, sel_ff, 1'b0, mode_ff, en_ff};
  wire [7:0] nxt_rdata = cfg_hit ? cfg_view :
    iowdg_pkg::IOWDG_TRIG_READ;

  iowdg_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clr(retrig || !en_ff),
    .o_tick(tick)
  );

  // Configuration fields written by the host.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      en_ff <= iowdg_pkg::IOWDG_CFG_RESET[iowdg_pkg::IOWDG_EN_BIT];
      mode_ff <= iowdg_pkg::IOWDG_CFG_RESET[iowdg_pkg::IOWDG_MODE_BIT];
      sel_ff <= iowdg_pkg::IOWDG_CFG_RESET[iowdg_pkg::IOWDG_SEL_LSB +: 3];
    end
    else if (cfg_wr)
    begin
      en_ff <= i_req.wdata[iowdg_pkg::IOWDG_EN_BIT];
      mode_ff <= i_req.wdata[iowdg_pkg::IOWDG_MODE_BIT];
      sel_ff <= i_req.wdata[iowdg_pkg::IOWDG_SEL_LSB +: 3];
    end
  end

  // Alarm and LED: expiry sets them and wins over a write-one clear.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      alarm_ff <= iowdg_pkg::IOWDG_CFG_RESET[iowdg_pkg::IOWDG_ALARM_BIT];
      led_ff <= iowdg_pkg::IOWDG_CFG_RESET[iowdg_pkg::IOWDG_LED_BIT];
    end
    else if (expire)
    begin
      alarm_ff <= 1'b1;
      led_ff <= 1'b1;
    end
    else if (clr_alarm)
    begin
      alarm_ff <= 1'b0;
      led_ff <= 1'b0;
    end
  end

  // Countdown and read port.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      ms_ff <= 17'h00000;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      ms_ff <= nxt_ms;
      rdata_ff <= i_req.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= i_req.rd && (cfg_hit || trig_hit);
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_led_on = led_ff;
  assign o_alarm = alarm_ff;
endmodule
`default_nettype wire

// ---- verification/iowdg_properties.sv ----
// Purpose: Port checks for the watchdog block.
// Assumes: Bound to iowdg_top.
// Notes: Reset switches every check off.
`default_nettype none
module iowdg_chk (
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rst_b, // Reset.
  input wire iowdg_pkg::iowdg_req_s i_req, // Request.
  input wire logic [7:0] o_rdata, // Data.
  input wire logic o_rvalid, // Valid.
  input wire logic o_led_on, // LED.
  input wire logic o_alarm // Alarm.
);
  // Decoded host accesses.
  wire logic rc = i_req.rd && i_req.addr == 16'h0062;
  wire logic rt = i_req.rd && i_req.addr == 16'h0066;
  wire logic cl = i_req.wr && i_req.addr == 16'h0062 && i_req.wdata[7];
  logic en_copy_ff;
  // Copy of the enable bit: an expiry can only race a clear while enabled.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      en_copy_ff <= 1'b0;
    else if (i_req.wr && i_req.addr == 16'h0062)
      en_copy_ff <= i_req.wdata[0];
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Read answers, alarm stickiness and the LED follow their causes.
  property p_t; rt |=> o_rvalid && o_rdata == 8'h00; endproperty
  a_t: assert property (p_t) else $error("trig");
  property p_c; rc |=> o_rvalid && !o_rdata[2]; endproperty
  a_c: assert property (p_c) else $error("cfg");
  property p_n; !(rc || rt) |=> !o_rvalid; endproperty
  a_n: assert property (p_n) else $error("none");
  property p_b; rc |=> o_rdata[7] == $past(o_alarm); endproperty
  a_b: assert property (p_b) else $error("bit");
  property p_l; o_led_on == o_alarm; endproperty
  a_l: assert property (p_l) else $error("led");
  property p_s; o_alarm && !cl |=> o_alarm; endproperty
  a_s: assert property (p_s) else $error("keep");
  property p_k; cl && o_alarm && !en_copy_ff |=> !o_alarm; endproperty
  a_k: assert property (p_k) else $error("clr");
  property p_r; $rose(o_alarm) |-> !$past(rt, 3); endproperty
  a_r: assert property (p_r) else $error("rise");
endmodule
bind iowdg_top iowdg_chk u_chk (.i_sys_clk, .i_rst_b, .i_req, .o_rdata,
  .o_rvalid, .o_led_on, .o_alarm);
`default_nettype wire

// ---- verification/test_iowdg_top.sv ----
// Purpose: Self-checking bench for the watchdog.
// Assumes: A tick of two cycles per millisecond.
// Notes: Inputs change on the falling edge.
`default_nettype none
module test_iowdg_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 2;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  iowdg_pkg::iowdg_req_s i_req = '0;
  logic [7:0] o_rdata;
  logic o_rvalid, o_led_on, o_alarm;
  int errors = 0;
  int check_count = 0;
  iowdg_top #(.TICK_CYCLES(TK)) u_dut (.i_sys_clk, .i_rst_b, .i_req,
    .o_rdata, .o_rvalid, .o_led_on, .o_alarm);
  // Clock of 40 ns.
  initial forever #20 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch t=%0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic io(input logic r, input logic [15:0] a, logic [7:0] d);
    i_req = '{a, d, r, !r};
    idle(1);
    i_req = '0;
    idle(1);
  endtask
  task automatic t_cfg();
    io(1, 16'h0062, 0);
    chk(o_rdata, 8'h00);
    io(0, 16'h0062, 8'h29);
    io(1, 16'h0063, 0);
    io(1, 16'h0062, 0);
    chk(o_rdata, 8'h29);
    io(1, 16'h0066, 0);
    chk(o_rdata, 8'h00);
    $display("cfg done");
  endtask
  task automatic t_expire();
    io(0, 16'h0062, 8'h01);
    idle(90 * TK);
    io(1, 16'h0066, 0);
    idle(90 * TK);
    chk(8'(o_alarm), 8'h00);
    idle(6 * TK);
    chk(8'(o_led_on), 8'h01);
    io(1, 16'h0062, 0);
    chk(o_rdata, 8'hc1);
    $display("expire done");
  endtask
  task automatic t_mode();
    io(0, 16'h0062, 8'h00);
    chk(8'(o_alarm), 8'h01);
    io(0, 16'h0062, 8'h82);
    chk(8'(o_alarm), 8'h00);
    io(0, 16'h0062, 8'h03);
    idle(100 * TK);
    chk(8'(o_alarm), 8'h00);
    io(0, 16'h0062, 8'h00);
    idle(100 * TK);
    chk(8'(o_alarm), 8'h00);
    $display("mode done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence after a 16-cycle reset.
  initial
  begin
    idle(16);
    i_rst_b = 1'b1;
    idle(1);
    t_cfg();
    t_expire();
    t_mode();
    give_verdict();
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (5000) @(posedge i_sys_clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
